// ==== rtl/dsc_pkg.sv ====
// dsc_pkg: shared constants and types of the dual switch channel control
package dsc_pkg;

  localparam int unsigned CLK_HZ          = 50_000_000;
  // wake-up time in microseconds, longest allowed
  localparam int unsigned WAKE_US         = 100;
  localparam int unsigned WAKE_CYCLES     = (WAKE_US * (CLK_HZ / 1_000_000));
  // overload fault delay per slew setting and for limit mode, in microseconds
  localparam int unsigned FAULT_US_SLEW1  = 10;
  localparam int unsigned FAULT_US_SLEW2  = 50;
  localparam int unsigned FAULT_US_LIMIT  = 10;
  localparam int unsigned FAULT_CYC_SLEW1 = (FAULT_US_SLEW1 * (CLK_HZ / 1_000_000));
  localparam int unsigned FAULT_CYC_SLEW2 = (FAULT_US_SLEW2 * (CLK_HZ / 1_000_000));
  localparam int unsigned FAULT_CYC_LIMIT = (FAULT_US_LIMIT * (CLK_HZ / 1_000_000));
  localparam int unsigned CNT_W           = 13;
  localparam int unsigned NCH             = 2;

  // how the output on command is formed
  typedef enum logic [1:0]
  {
    DSC_COMB_PIN = 2'h0,
    DSC_COMB_SER = 2'h1,
    DSC_COMB_OR  = 2'h2,
    DSC_COMB_AND = 2'h3
  } dsc_comb_t;

  typedef enum logic [1:0]
  {
    DSC_AWAKE  = 2'b00,
    DSC_ASLEEP = 2'b01,
    DSC_WAKING = 2'b10
  } dsc_pwr_t;

  // per-channel serial configuration
  typedef struct packed
  {
    dsc_comb_t input_combine_select;
    logic      slew_select;
    logic      limit_shutdown;
  } dsc_cfg_t;

  // per-channel analog fault inputs
  typedef struct packed
  {
    logic overcurrent;
    logic overtemp;
  } dsc_fault_t;

endpackage

// ==== rtl/dsc_sync.sv ====
// dsc_sync: three-stage synchroniser with agreement check
`timescale 1ns/10ps
`default_nettype none
module dsc_sync
  import dsc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic din,
  output var  logic dout
);

  logic       s1;
  logic       s2;
  logic       s3;
  logic       next_dout;

  always_comb
  begin
    next_dout = dout;
    if (s2 == s3)
    begin
      next_dout = s3;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1   <= 1'b0;
      s2   <= 1'b0;
      s3   <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      s1   <= din;
      s2   <= s1;
      s3   <= s2;
      dout <= next_dout;
    end
  end

endmodule
`default_nettype wire

// ==== rtl/dsc_ctrl.sv ====
// dsc_ctrl: sleep, output command and overload control of two low-side channels
`timescale 1ns/10ps
`default_nettype none
module dsc_ctrl
  import dsc_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 channel_one_input,
  input  wire logic                 channel_two_input,
  input  wire logic [NCH-1:0]       serial_channel_on_bit,
  input  wire logic                 serial_on_load,
  input  wire dsc_cfg_t [NCH-1:0]   cfg,
  input  wire logic                 cfg_load,
  input  wire logic                 sleep_cmd,
  input  wire logic                 wake_cmd,
  input  wire logic                 serial_diag,
  input  wire logic                 transfer_done,
  input  wire dsc_fault_t [NCH-1:0] fault,
  output logic                      channel_one_output,
  output logic                      channel_two_output,
  output logic [NCH-1:0]            slew_out,
  output logic [NCH-1:0]            overload_flag,
  output logic                      diag_enable,
  output logic                      asleep
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [NCH-1:0] pin_raw;
  logic [NCH-1:0] pin;
  logic [NCH-1:0] oc;
  logic [NCH-1:0] ot;

  assign pin_raw = {channel_two_input, channel_one_input};

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_sync
      dsc_sync u_pin (.clk(clk), .rst_n(rst_n), .din(pin_raw[gi]), .dout(pin[gi]));
      dsc_sync u_oc  (.clk(clk), .rst_n(rst_n), .din(fault[gi].overcurrent), .dout(oc[gi]));
      dsc_sync u_ot  (.clk(clk), .rst_n(rst_n), .din(fault[gi].overtemp), .dout(ot[gi]));
    end
  endgenerate

  // ---------------------------------------------------------------
  // power state
  // ---------------------------------------------------------------
  dsc_pwr_t         pwr;
  dsc_pwr_t         next_pwr;
  logic [CNT_W-1:0] wake_cnt;
  logic [CNT_W-1:0] next_wake_cnt;

  always_comb
  begin
    next_pwr      = pwr;
    next_wake_cnt = wake_cnt;
    case (pwr)
      DSC_AWAKE:
      begin
        if (sleep_cmd)
        begin
          next_pwr = DSC_ASLEEP;
        end
      end
      DSC_ASLEEP:
      begin
        if (wake_cmd)
        begin
          next_pwr      = DSC_WAKING;
          next_wake_cnt = CNT_W'(WAKE_CYCLES - 1);
        end
      end
      DSC_WAKING:
      begin
        if (sleep_cmd)
        begin
          next_pwr = DSC_ASLEEP;
        end
        else if (wake_cnt == '0)
        begin
          next_pwr = DSC_AWAKE;
        end
        else
        begin
          next_wake_cnt = wake_cnt - CNT_W'(1);
        end
      end
      default:
      begin
        next_pwr = DSC_AWAKE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pwr      <= DSC_AWAKE;
      wake_cnt <= '0;
    end
    else
    begin
      pwr      <= next_pwr;
      wake_cnt <= next_wake_cnt;
    end
  end

  logic awake;
  assign awake       = (pwr == DSC_AWAKE);
  assign asleep      = (pwr != DSC_AWAKE);
  assign diag_enable = awake;

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  dsc_cfg_t [NCH-1:0] cfg_q;
  dsc_cfg_t [NCH-1:0] next_cfg_q;
  logic [NCH-1:0]     ser_on;
  logic [NCH-1:0]     next_ser_on;

  always_comb
  begin
    next_cfg_q  = cfg_q;
    next_ser_on = ser_on;
    if (cfg_load)
    begin
      next_cfg_q = cfg;
    end
    if (serial_on_load)
    begin
      next_ser_on = serial_channel_on_bit;
    end
    if (sleep_cmd && awake)
    begin
      next_ser_on = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        cfg_q[i] <= '{input_combine_select: DSC_COMB_PIN, slew_select: 1'b0, limit_shutdown: 1'b1};
      end
      ser_on <= '0;
    end
    else
    begin
      cfg_q  <= next_cfg_q;
      ser_on <= next_ser_on;
    end
  end

  // ---------------------------------------------------------------
  // per-channel command, overload and output
  // ---------------------------------------------------------------
  logic [NCH-1:0]   cmd_on;
  logic [NCH-1:0]   latch;
  logic [NCH-1:0]   next_latch;
  logic [NCH-1:0]   flag;
  logic [NCH-1:0]   next_flag;
  logic [NCH-1:0]   drive;
  logic [NCH-1:0]   next_drive;
  logic [NCH-1:0]   fault_due;
  logic [CNT_W-1:0] fcnt [NCH];
  logic [CNT_W-1:0] next_fcnt [NCH];
  logic [CNT_W-1:0] fdelay [NCH];

  generate
    for (gi = 0; gi < NCH; gi++)
    begin : g_ch
      always_comb
      begin
        case (cfg_q[gi].input_combine_select)
          DSC_COMB_PIN: cmd_on[gi] = pin[gi];
          DSC_COMB_SER: cmd_on[gi] = ser_on[gi];
          DSC_COMB_OR:  cmd_on[gi] = pin[gi] | ser_on[gi];
          DSC_COMB_AND: cmd_on[gi] = pin[gi] & ser_on[gi];
          default:      cmd_on[gi] = pin[gi];
        endcase
      end

      assign fdelay[gi] = !cfg_q[gi].limit_shutdown ? CNT_W'(FAULT_CYC_LIMIT) :
                          cfg_q[gi].slew_select ? CNT_W'(FAULT_CYC_SLEW2) : CNT_W'(FAULT_CYC_SLEW1);
      assign fault_due[gi] = oc[gi] && drive[gi] && (fcnt[gi] >= fdelay[gi] - CNT_W'(1));

      always_comb
      begin
        next_fcnt[gi]  = '0;
        next_latch[gi] = latch[gi];
        next_flag[gi]  = flag[gi];
        if (oc[gi] && drive[gi] && awake && !fault_due[gi])
        begin
          next_fcnt[gi] = fcnt[gi] + CNT_W'(1);
        end
        if (!cmd_on[gi])
        begin
          next_latch[gi] = 1'b0;
        end
        if (!serial_diag && !oc[gi])
        begin
          next_flag[gi] = 1'b0;
        end
        if (serial_diag && transfer_done)
        begin
          if (!cfg_q[gi].limit_shutdown || !pin[gi])
          begin
            next_flag[gi] = 1'b0;
          end
        end
        if (fault_due[gi] && awake)
        begin
          next_flag[gi] = 1'b1;
          if (cfg_q[gi].limit_shutdown)
          begin
            next_latch[gi] = 1'b1;
          end
        end
        next_drive[gi] = awake && cmd_on[gi] && !ot[gi] && !next_latch[gi];
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      latch <= '0;
      flag  <= '0;
      drive <= '0;
      for (int i = 0; i < NCH; i++)
      begin
        fcnt[i] <= '0;
      end
    end
    else
    begin
      latch <= next_latch;
      flag  <= next_flag;
      drive <= next_drive;
      for (int i = 0; i < NCH; i++)
      begin
        fcnt[i] <= next_fcnt[i];
      end
    end
  end

  assign channel_one_output = drive[0];
  assign channel_two_output = drive[1];
  assign overload_flag      = flag;

  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      slew_out[i] = cfg_q[i].slew_select;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  sequence sleep_entry_s;
    awake && sleep_cmd;
  endsequence

  sleep_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    sleep_entry_s |=> ##1 (!channel_one_output && !channel_two_output))
    else $error("outputs not off in sleep");
  sleep_onbits_a: assert property (@(posedge clk) disable iff (!rst_n)
    sleep_entry_s |=> (ser_on == '0))
    else $error("serial on bits kept in sleep");

  // cycles spent waking
  logic [CNT_W-1:0] wake_age;
  logic [CNT_W-1:0] next_wake_age;

  assign next_wake_age = (pwr == DSC_WAKING) ? wake_age + CNT_W'(1) : '0;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wake_age <= '0;
    end
    else
    begin
      wake_age <= next_wake_age;
    end
  end

  wake_time_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pwr == DSC_WAKING) |-> (wake_age < CNT_W'(WAKE_CYCLES)))
    else $error("wake took too long");
  shut_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
    fault_due[0] && awake && cfg_q[0].limit_shutdown |=> !channel_one_output)
    else $error("channel one not shut down");
  latch_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    latch[1] && cmd_on[1] |=> !channel_two_output)
    else $error("latched channel turned on");
  limit_stay_a: assert property (@(posedge clk) disable iff (!rst_n)
    fault_due[0] && awake && !cfg_q[0].limit_shutdown && cmd_on[0] && !ot[0] && !latch[0]
      |=> channel_one_output && overload_flag[0])
    else $error("limit mode dropped channel");
  status_clr_a: assert property (@(posedge clk) disable iff (!rst_n)
    !serial_diag && !oc[0] && !fault_due[0] |=> !overload_flag[0])
    else $error("status flag not cleared");
  pin_high_a: assert property (@(posedge clk) disable iff (!rst_n)
    serial_diag && transfer_done && cfg_q[0].limit_shutdown && pin[0] && overload_flag[0]
      |=> overload_flag[0])
    else $error("flag cleared with pin high");
  overtemp_a: assert property (@(posedge clk) disable iff (!rst_n)
    ot[1] |=> !channel_two_output)
    else $error("overtemp did not switch off");

endmodule
`default_nettype wire

// ==== bench/dsc_host.sv ====
// dsc_host: host model driving the channel pins and serial commands
`timescale 1ns/10ps
`default_nettype none
module dsc_host
  import dsc_pkg::*;
(
  input  wire logic               clk,
  output var  logic               channel_one_input,
  output var  logic               channel_two_input,
  output var  logic [NCH-1:0]     serial_channel_on_bit,
  output var  dsc_cfg_t [NCH-1:0] cfg,
  output var  logic               serial_diag,
  output var  logic               cfg_load,
  output var  logic               serial_on_load,
  output var  logic               sleep_cmd,
  output var  logic               wake_cmd,
  output var  logic               transfer_done
);

  initial
  begin
    cfg_load = 1'b0;
    serial_on_load = 1'b0;
    sleep_cmd = 1'b0;
    wake_cmd = 1'b0;
    transfer_done = 1'b0;
    channel_one_input = 1'b0;
    channel_two_input = 1'b0;
    serial_channel_on_bit = 2'h0;
    cfg = '0;
    serial_diag = 1'b0;
  end

  // ---------------------------------------------
  // command pulses
  // ---------------------------------------------
  // wake pulse too
  task automatic fire(input logic [4:0] p);
    @(posedge clk) {cfg_load, serial_on_load, sleep_cmd, wake_cmd, transfer_done} <= p;
    @(posedge clk) {cfg_load, serial_on_load, sleep_cmd, wake_cmd, transfer_done} <= 5'h00;
  endtask

  task automatic set_cfg(input dsc_cfg_t [NCH-1:0] c);
    @(posedge clk) cfg <= c;
    fire(5'h10);
  endtask

  task automatic set_on(input logic [NCH-1:0] s);
    @(posedge clk) serial_channel_on_bit <= s;
    fire(5'h08);
  endtask

  task automatic pins(input logic a, input logic b);
    @(posedge clk) channel_one_input <= a;
    channel_two_input <= b;
  endtask

  task automatic diag(input logic d);
    @(posedge clk) serial_diag <= d;
  endtask
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// testbench: random and corner checks of the channel control
`timescale 1ns/10ps
`default_nettype none
module testbench
  import dsc_pkg::*;
  ;
  logic                 clk = 1'b0;
  logic                 rst_n = 1'b0;
  dsc_fault_t [NCH-1:0] fault = '0;
  dsc_cfg_t [NCH-1:0]   cfg;
  dsc_cfg_t [NCH-1:0]   cr;
  logic                 c1in, c2in, ser_ld, cfg_ld, slp, wk, sd, td;
  logic                 o1, o2, diag, asleep;
  logic [NCH-1:0]       son, slew, flag, p, s;
  int                   miscompares = 0;
  int                   checks = 0;
  int                   cycles = 0;
  wire logic [7:0]      st = {asleep, diag, slew, flag, o2, o1};

  always #10 clk = ~clk;

  dsc_host i_host (.clk(clk), .channel_one_input(c1in), .channel_two_input(c2in),
    .serial_channel_on_bit(son), .cfg(cfg), .serial_diag(sd), .cfg_load(cfg_ld),
    .serial_on_load(ser_ld), .sleep_cmd(slp), .wake_cmd(wk), .transfer_done(td));

  dsc_ctrl i_dut (.clk(clk), .rst_n(rst_n), .channel_one_input(c1in),
    .channel_two_input(c2in), .serial_channel_on_bit(son), .serial_on_load(ser_ld),
    .cfg(cfg), .cfg_load(cfg_ld), .sleep_cmd(slp), .wake_cmd(wk), .serial_diag(sd),
    .transfer_done(td), .fault(fault), .channel_one_output(o1), .channel_two_output(o2),
    .slew_out(slew), .overload_flag(flag), .diag_enable(diag), .asleep(asleep));

  // ---------------------------------------------
  // compare and verdict
  // ---------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  function automatic logic exp_on(input dsc_comb_t m, input logic pin, input logic ser);
    case (m)
      DSC_COMB_PIN: return pin;
      DSC_COMB_SER: return ser;
      DSC_COMB_OR:  return pin | ser;
      default:      return pin & ser;
    endcase
  endfunction

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      miscompares++;
      give_verdict();
    end
  end

  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial
  begin
    void'($urandom(90));
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    cyc(8);
    i_host.pins(1'b1, 1'b0);
    cyc(8);
    chk(st, 8'h41);
    i_host.pins(1'b0, 1'b1);
    cyc(8);
    chk(st, 8'h42);
    for (int i = 0; i < 24; i++)
    begin
      cr = 8'($urandom);
      cr[0].input_combine_select = dsc_comb_t'(i % 4);
      p = 2'($urandom);
      s = 2'($urandom);
      i_host.set_cfg(cr);
      i_host.set_on(s);
      i_host.pins(p[0], p[1]);
      cyc(8);
      chk({slew, o2, o1}, {cr[1].slew_select, cr[0].slew_select, exp_on(cr[1].input_combine_select, p[1], s[1]),
          exp_on(cr[0].input_combine_select, p[0], s[0])});
    end
    i_host.set_cfg({DSC_COMB_PIN, 2'b01, DSC_COMB_PIN, 2'b00});
    i_host.pins(1'b1, 1'b1);
    cyc(8);
    @(posedge clk) fault[0].overcurrent <= 1'b1;
    cyc(400);
    chk({flag, o2, o1}, 4'h3);
    cyc(130);
    chk({flag, o2, o1}, 4'h7);
    @(posedge clk) fault[0].overcurrent <= 1'b0;
    cyc(8);
    chk({flag, o2, o1}, 4'h3);
    i_host.diag(1'b1);
    i_host.set_cfg({DSC_COMB_PIN, 2'b01, DSC_COMB_PIN, 2'b01});
    @(posedge clk) fault[0].overcurrent <= 1'b1;
    cyc(400);
    chk({flag, o2, o1}, 4'h3);
    cyc(130);
    chk({flag, o2, o1}, 4'h6);
    @(posedge clk) fault[0].overcurrent <= 1'b0;
    cyc(8);
    chk({flag, o2, o1}, 4'h6);
    i_host.fire(5'h01);
    cyc(4);
    chk({flag, o2, o1}, 4'h6);
    i_host.pins(1'b0, 1'b1);
    cyc(8);
    i_host.fire(5'h01);
    cyc(4);
    chk({flag, o2, o1}, 4'h2);
    i_host.pins(1'b1, 1'b1);
    cyc(8);
    chk({flag, o2, o1}, 4'h3);
    i_host.set_cfg({DSC_COMB_PIN, 2'b11, DSC_COMB_PIN, 2'b01});
    @(posedge clk) fault[1].overcurrent <= 1'b1;
    cyc(2400);
    chk({flag, o2, o1}, 4'h3);
    cyc(130);
    chk({flag, o2, o1}, 4'h9);
    @(posedge clk) fault[1].overcurrent <= 1'b0;
    i_host.pins(1'b1, 1'b0);
    cyc(8);
    i_host.fire(5'h01);
    cyc(4);
    chk({flag, o2, o1}, 4'h1);
    i_host.pins(1'b1, 1'b1);
    cyc(8);
    @(posedge clk) fault[0].overtemp <= 1'b1;
    cyc(8);
    chk({o2, o1}, 2'h2);
    @(posedge clk) fault[0].overtemp <= 1'b0;
    cyc(8);
    chk({o2, o1}, 2'h3);
    @(posedge clk) fault[1].overtemp <= 1'b1;
    cyc(8);
    chk({o2, o1}, 2'h1);
    @(posedge clk) fault[1].overtemp <= 1'b0;
    cyc(8);
    chk({o2, o1}, 2'h3);
    i_host.set_cfg({DSC_COMB_PIN, 2'b01, DSC_COMB_SER, 2'b11});
    i_host.set_on(2'h1);
    i_host.pins(1'b0, 1'b1);
    cyc(8);
    chk(st, 8'h53);
    i_host.fire(5'h04);
    cyc(3);
    chk({asleep, diag, o2, o1}, 4'h8);
    i_host.fire(5'h02);
    cyc(4900);
    chk({asleep, diag}, 2'h2);
    cyc(103);
    chk(st, 8'h52);
    give_verdict();
  end
endmodule
`default_nettype wire
